// file: elbi_pkg.sv
package elbi_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned CLK_DIV    = 4;
   localparam logic [1:0]  PH_ADDR    = 2'h0;
   localparam logic [1:0]  PH_LATCH   = 2'h1;
   localparam logic [1:0]  PH_STROBE  = 2'h2;
   localparam logic [1:0]  PH_END     = 2'h3;
   localparam logic [1:0]  PH_RESET   = 2'h0;

   // ----------------------------------------------------------------
   // Reset width
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS   = 25000;
   localparam int unsigned RST_MIN_NS      = 2000;
   localparam int unsigned RST_MIN_CYC     =
      (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0]  RST_CNT_RESET   = 8'h00;

   typedef enum logic [1:0]
   {
      ELBI_KIND_FETCH = 2'h0,
      ELBI_KIND_READ  = 2'h1,
      ELBI_KIND_WRITE = 2'h2
   } elbi_kind_e;

   typedef struct packed
   {
      elbi_kind_e          kind;
      logic                data_space;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } elbi_req_s;

   typedef struct packed
   {
      logic                sync;
      logic                rd_n;
      logic                wr_n;
      logic                ale;
      logic                data_space_select_n;
   } elbi_ctl_s;

   localparam elbi_ctl_s CTL_IDLE = '{sync: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                                      ale: 1'b0, data_space_select_n: 1'b1};

endpackage : elbi_pkg

// file: elbi_clkdiv.sv
`timescale 1ns/100ps

// Divides the oscillator-rate clock into bus phases and the timing clock
module elbi_clkdiv
   import elbi_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // Phase outputs
   output logic [1:0]      phase_o,
   output logic            tclk_o
);

   logic [1:0] phase_q;
   logic [1:0] phase_d;
   logic       tclk_q;
   logic       tclk_d;

   assign phase_d = phase_q + 2'h1;
   // High in the first half of the period, low in the strobe half
   assign tclk_d  = (phase_d == PH_ADDR) || (phase_d == PH_LATCH);

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         phase_q <= PH_RESET;
         // Phase 0 is a high phase; a low reset value gave a short pulse
         tclk_q  <= 1'b1;
      end
      else
      begin
         phase_q <= phase_d;
         tclk_q  <= tclk_d;
      end
   end

   assign phase_o = phase_q;
   assign tclk_o  = tclk_q;

endmodule : elbi_clkdiv

// file: elbi_bus.sv
`timescale 1ns/100ps

module elbi_bus
   import elbi_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rst_n_i,
   // Core request side
   input  wire logic               req_valid_i,
   input  wire elbi_req_s          req_i,
   output logic                    req_ready_o,
   output logic                    rsp_valid_o,
   output logic [DATA_W-1:0]       rsp_data_o,
   // Pin function select
   input  wire logic               expand_en_i,
   input  wire logic               port_bit_i,
   // Reset qualification
   output logic                    rst_width_ok_o,
   // Local bus pins
   output logic                    tclk_o,
   output logic                    sync_o,
   output logic                    rd_n_o,
   output logic                    wr_n_o,
   output logic                    ale_o,
   output logic [7:0]              high_address_byte_o,
   input  wire logic [7:0]         muxed_low_addr_data_i,
   output logic [7:0]              muxed_low_addr_data_o,
   output logic                    muxed_low_addr_data_oe_o,
   output logic                    data_space_select_o
);

   // ----------------------------------------------------------------
   // Phase generation
   // ----------------------------------------------------------------
   logic [1:0] phase;

   elbi_clkdiv u_clkdiv
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .phase_o   (phase),
      .tclk_o    (tclk_o)
   );

   typedef enum logic [0:0]
   {
      ELBI_ST_IDLE = 1'b0,
      ELBI_ST_BUSY = 1'b1
   } elbi_state_e;

   // ----------------------------------------------------------------
   // Cycle tracking
   // ----------------------------------------------------------------
   elbi_state_e       state_q;
   elbi_state_e       state_d;
   elbi_req_s         cur_q;
   elbi_req_s         cur_d;
   elbi_ctl_s         ctl_q;
   elbi_ctl_s         ctl_d;
   logic [7:0]        hi_q;
   logic [7:0]        hi_d;
   logic [7:0]        ad_q;
   logic [7:0]        ad_d;
   logic              ad_oe_q;
   logic              ad_oe_d;
   logic              rsp_v_q;
   logic              rsp_v_d;
   logic [7:0]        rsp_q;
   logic [7:0]        rsp_d;
   logic              dss_q;
   logic              dss_d;

   // Requests are only taken at the last phase so each cycle starts
   // aligned with a rising timing clock.
   wire logic        at_end    = (phase == PH_END);
   wire logic        start     = at_end && req_valid_i;
   wire logic        busy      = (state_q == ELBI_ST_BUSY);
   wire logic        is_fetch  = (cur_q.kind == ELBI_KIND_FETCH);
   wire logic        is_write  = (cur_q.kind == ELBI_KIND_WRITE);
   wire logic        is_data   = !is_fetch;
   wire logic        to_latch  = busy && (phase == PH_ADDR);
   wire logic        to_strobe = busy && (phase == PH_LATCH);
   wire logic        to_end    = busy && (phase == PH_STROBE);
   wire logic        finish    = busy && at_end;
   // Decode of the request as it is taken
   wire logic        req_fetch = (req_i.kind == ELBI_KIND_FETCH);
   // Select is active only for data in the second space
   wire logic        req_ds    = !req_fetch && req_i.data_space;

   // Ready is a plain level; a request outside phase 3 just waits
   assign req_ready_o = at_end;

   // ----------------------------------------------------------------
   // Cycle map
   // ----------------------------------------------------------------
   // One access takes four oscillator cycles, one timing clock period.
   // Taken at the edge that ends phase 3, it then runs:
   //   phase 0  latch strobe high, low address on the shared lines,
   //            high address byte, fetch marker and space select set
   //   phase 1  latch strobe low; the low address stays driven so the
   //            external latch sees it settle through the falling edge
   //   phase 2  read or write strobe low; write data replaces the
   //            address, or the shared lines are released for a read
   //   phase 3  strobes high again; read data was taken at the edge
   //            that opened this phase, while the read strobe was low
   // A new request may be taken at the end of phase 3, so accesses run
   // back to back with no idle phase between them.
   //
   // After reset the divider sits in phase 0 with the timing clock
   // high, so the first request is taken on the fourth edge after
   // reset lets go.
   //
   // Limitations worth knowing:
   //   - The read strobe is low for one oscillator cycle only, so the
   //     memory must answer inside that cycle; there is no wait input.
   //   - The high address byte keeps its last value after an access,
   //     which gives hold time but says nothing about bus ownership.
   //   - The core sees only the ready level; nothing reports a request
   //     that was not taken.
   //   - The fetch marker spans the whole access, not only the strobe.

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      cur_d   = cur_q;
      ctl_d   = ctl_q;
      hi_d    = hi_q;
      ad_d    = ad_q;
      ad_oe_d = ad_oe_q;
      rsp_v_d = 1'b0;
      rsp_d   = rsp_q;
      if (start)
      begin
         // Address phase: high byte held, low byte on shared lines
         state_d   = ELBI_ST_BUSY;
         cur_d     = req_i;
         hi_d      = req_i.addr[15:8];
         ad_d      = req_i.addr[7:0];
         ad_oe_d   = 1'b1;
         ctl_d     = CTL_IDLE;
         ctl_d.ale = 1'b1;
         ctl_d.sync = req_fetch;
         ctl_d.data_space_select_n = !req_ds;
      end
      else if (finish)
      begin
         // Markers back to idle, shared lines released; write data was held a phase past the strobe
         state_d = ELBI_ST_IDLE;
         ctl_d   = CTL_IDLE;
         ad_oe_d = 1'b0;
      end
      else if (to_latch)
      begin
         ctl_d.ale = 1'b0;
      end
      else if (to_strobe)
      begin
         // Data phase, second half of the timing clock period
         ctl_d.rd_n = is_write;
         ctl_d.wr_n = !is_write;
         ad_d       = is_write ? cur_q.wdata : ad_q;
         ad_oe_d    = is_write;
      end
      else if (to_end)
      begin
         // Sample read data before the strobe rises
         if (!is_write)
         begin
            rsp_v_d = 1'b1;
            rsp_d   = muxed_low_addr_data_i;
         end
         ctl_d.rd_n = 1'b1;
         ctl_d.wr_n = 1'b1;
      end
   end

   // The shared pin becomes a plain port bit when expansion is off
   assign dss_d = expand_en_i ? ctl_d.data_space_select_n
                              : port_bit_i;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // All bus state but the divider's phase and timing clock in one bank; the reset values are an idle bus
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ELBI_ST_IDLE;
         cur_q   <= '0;
         ctl_q   <= CTL_IDLE;
         hi_q    <= 8'h00;
         ad_q    <= 8'h00;
         ad_oe_q <= 1'b0;
         rsp_v_q <= 1'b0;
         rsp_q   <= 8'h00;
         dss_q   <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         cur_q   <= cur_d;
         ctl_q   <= ctl_d;
         hi_q    <= hi_d;
         ad_q    <= ad_d;
         ad_oe_q <= ad_oe_d;
         rsp_v_q <= rsp_v_d;
         rsp_q   <= rsp_d;
         dss_q   <= dss_d;
      end
   end

   // ----------------------------------------------------------------
   // Reset width monitor
   // ----------------------------------------------------------------
   // The asynchronous reset clears every flop that could count it, so
   // the width is counted on reset-free flops. They are two-state so a
   // fresh power-up reads as a short reset rather than an unknown one.
   logic       rst_seen_q;
   bit   [7:0] low_cnt_q;
   bit   [7:0] low_cnt_d;
   bit         width_ok_q;
   wire logic  low_full = (low_cnt_q == 8'(RST_MIN_CYC));

   // Saturates so a very long reset cannot wrap back to short
   assign low_cnt_d = low_full ? low_cnt_q : low_cnt_q + 8'h01;

   // Marks the first clock edge after reset has let go
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_seen_q <= 1'b0;
      else
         rst_seen_q <= 1'b1;
   end

   // Counts low samples; cleared as soon as reset is high again
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         low_cnt_q <= low_cnt_d;
      else
         low_cnt_q <= RST_CNT_RESET;
   end

   // Verdict is refreshed only while reset is low and held after it
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         width_ok_q <= low_full;
      else
         width_ok_q <= width_ok_q;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sync_o                   = ctl_q.sync;
   assign rd_n_o                   = ctl_q.rd_n;
   assign wr_n_o                   = ctl_q.wr_n;
   assign ale_o                    = ctl_q.ale;
   assign high_address_byte_o      = hi_q;
   assign muxed_low_addr_data_o    = ad_q;
   assign muxed_low_addr_data_oe_o = ad_oe_q;
   assign data_space_select_o      = dss_q;
   assign rsp_valid_o              = rsp_v_q;
   assign rsp_data_o               = rsp_q;
   assign rst_width_ok_o           = width_ok_q && rst_seen_q;

endmodule : elbi_bus

// file: elbi_bus_assertions.sv
`timescale 1ns/100ps
module elbi_bus_chk
   import elbi_pkg::*;
(
   // Clock, reset and request side
   input wire logic            ref_clk_i,
   input wire logic            rst_n_i,
   input wire logic            req_valid_i,
   input wire elbi_req_s       req_i,
   input wire logic            req_ready_o,
   input wire logic            rsp_valid_o,
   input wire logic [DATA_W-1:0] rsp_data_o,
   input wire logic            expand_en_i,
   // Local bus pins
   input wire logic            tclk_o,
   input wire logic            sync_o,
   input wire logic            rd_n_o,
   input wire logic            wr_n_o,
   input wire logic            ale_o,
   input wire logic [7:0]      high_address_byte_o,
   input wire logic [7:0]      muxed_low_addr_data_i,
   input wire logic [7:0]      muxed_low_addr_data_o,
   input wire logic            muxed_low_addr_data_oe_o,
   input wire logic            data_space_select_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire take = req_valid_i && req_ready_o;
   wire wr   = req_i.kind == ELBI_KIND_WRITE;
   wire ftch = req_i.kind == ELBI_KIND_FETCH;

   a_tclk_quarter: assert property ($rose(tclk_o) |=>
      tclk_o ##1 (!tclk_o)[*2] ##1 tclk_o) else $error("bad tclk");
   a_fetch_sync: assert property (take && ftch |=> sync_o[*4])
      else $error("sync missing");
   a_read_strobe: assert property (take && !wr |=>
      (rd_n_o && wr_n_o)[*2] ##1 (!rd_n_o && wr_n_o && !muxed_low_addr_data_oe_o)
      ##1 (rd_n_o && rsp_valid_o)) else $error("bad read cycle");
   a_write_strobe: assert property (take && wr |=>
      (rd_n_o && wr_n_o)[*2] ##1 (!wr_n_o && rd_n_o) ##1 wr_n_o)
      else $error("bad write cycle");
   a_addr_phase: assert property (take |=> ale_o &&
      muxed_low_addr_data_oe_o && muxed_low_addr_data_o ==
      $past(req_i.addr[7:0]) ##1 !ale_o) else $error("bad addr phase");
   a_high_hold: assert property (take |=> high_address_byte_o ==
      $past(req_i.addr[15:8]) ##1 $stable(high_address_byte_o)[*3])
      else $error("high byte moved");
   a_write_data: assert property (take && wr |=> ##2
      muxed_low_addr_data_oe_o && muxed_low_addr_data_o ==
      $past(req_i.wdata, 3)) else $error("bad write data");
   a_space_sel: assert property (take && expand_en_i |=>
      data_space_select_o == !($past(req_i.data_space) && !$past(ftch)))
      else $error("bad space select");
   a_rsp_data: assert property (rsp_valid_o |->
      rsp_data_o == $past(muxed_low_addr_data_i)) else $error("bad rsp");
endmodule : elbi_bus_chk

bind elbi_bus elbi_bus_chk u_chk (.*);

// file: elbi_mem_model.sv
`timescale 1ns/100ps
// Two 64K data spaces, picked by the select pin
module elbi_mem_model
   import elbi_pkg::*;
(
   // Bus pins seen from the memory side
   input  wire logic       ref_clk_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic       ale_i,
   input  wire logic       data_space_select_i,
   input  wire logic [7:0] high_address_byte_i,
   input  wire logic [7:0] bus_i,
   // Read data toward the shared lines
   output logic [7:0]      bus_o
);
   logic [7:0] mem [bit [16:0]];
   logic [7:0] low_q = 8'h00;
   logic [7:0] rdat  = 8'h00;
   wire  [16:0] loc  = {~data_space_select_i, high_address_byte_i, low_q};
   // Released lines show the inverse so a stale byte never passes as data
   assign bus_o = rd_n_i ? ~rdat : rdat;
   always @(negedge ale_i) low_q = bus_i;
   always @(negedge rd_n_i) rdat = mem.exists(loc) ? mem[loc] : 8'h5A;
   always @(posedge ref_clk_i)
      if (!wr_n_i)
         mem[loc] = bus_i;
endmodule : elbi_mem_model

// file: elbi_bus_tb.sv
`timescale 1ns/100ps
module elbi_bus_tb
   import elbi_pkg::*;
   ;
   logic clk = 0, rst_n = 0, req_valid = 0, expand_en = 1, port_bit = 0;
   elbi_req_s req = '0;
   logic rdy, rv, ok, tclk, sync, rd_n, wr_n, ale, oe, dsel;
   logic [7:0] rdata, hi, ad_o, ad_in, mem_o;
   int failures = 0, cmp_count = 0;

   assign ad_in = oe ? ad_o : mem_o;
   elbi_bus dut (.ref_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
      .req_i(req), .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rdata),
      .expand_en_i(expand_en), .port_bit_i(port_bit), .rst_width_ok_o(ok),
      .tclk_o(tclk), .sync_o(sync), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .ale_o(ale), .high_address_byte_o(hi), .muxed_low_addr_data_i(ad_in),
      .muxed_low_addr_data_o(ad_o), .muxed_low_addr_data_oe_o(oe),
      .data_space_select_o(dsel));
   elbi_mem_model mem (.ref_clk_i(clk), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .ale_i(ale), .data_space_select_i(dsel), .high_address_byte_i(hi),
      .bus_i(ad_in), .bus_o(mem_o));

   initial forever #12.5 clk = ~clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   // -----------------------------------------------------------------
   // One access, entered at a falling edge; leaves valid up so the
   // caller may chain the next access back to back
   // -----------------------------------------------------------------
   task automatic op(input elbi_kind_e k, input logic sp,
                     input logic [15:0] a, input logic [7:0] d, e);
      int  n;
      logic s;
      n = 0;
      s = expand_en ? !(sp && k != ELBI_KIND_FETCH) : port_bit;
      req_valid = 1;
      req = '{kind: k, data_space: sp, addr: a, wdata: d};
      while (rdy !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      chk(rdy, 1);
      @(negedge clk);
      chk({ale, oe, sync, dsel, hi},
          {1'b1, 1'b1, k == ELBI_KIND_FETCH, s, a[15:8]});
      chk(ad_o, a[7:0]);
      repeat (2) @(negedge clk);
      chk({rd_n, wr_n}, (k == ELBI_KIND_WRITE) ? 2'b10 : 2'b01);
      @(negedge clk);
      chk(rv, k != ELBI_KIND_WRITE);
      if (k != ELBI_KIND_WRITE)
         chk(rdata, e);
   endtask : op

   task automatic t_reset;
      chk(ok, 0);
      rst_n = 0;
      repeat (2) @(negedge clk);
      chk({rd_n, wr_n, ale, sync, oe}, 5'b11000);
      repeat (88) @(negedge clk);
      rst_n = 1;
      repeat (2) @(negedge clk);
      chk(ok, 1);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_tclk;
      logic [7:0] s;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         s[i] = tclk;
      end
      chk({s[7:4] ^ s[3:0], s[0] ^ s[2], s[1] ^ s[3]}, 6'h03);
      $display("t_tclk done");
   endtask : t_tclk

   task automatic t_rw;
      op(ELBI_KIND_WRITE, 0, 16'h0000, 8'h3C, 8'h00);
      op(ELBI_KIND_WRITE, 1, 16'h0000, 8'hC3, 8'h00);
      op(ELBI_KIND_WRITE, 1, 16'hFFFF, 8'h81, 8'h00);
      op(ELBI_KIND_READ, 0, 16'h0000, 8'h00, 8'h3C);
      op(ELBI_KIND_READ, 1, 16'h0000, 8'h00, 8'hC3);
      // With expansion on, a fetch always goes to the program space
      op(ELBI_KIND_FETCH, 1, 16'h0000, 8'h00, 8'h3C);
      op(ELBI_KIND_FETCH, 0, 16'hFFFF, 8'h00, 8'h5A);
      op(ELBI_KIND_READ, 1, 16'hFFFF, 8'h00, 8'h81);
      req_valid = 0;
      $display("t_rw done");
   endtask : t_rw

   task automatic t_port;
      expand_en = 0;
      port_bit = 1;
      op(ELBI_KIND_READ, 1, 16'h0000, 8'h00, 8'h3C);
      port_bit = 0;
      op(ELBI_KIND_READ, 0, 16'h0000, 8'h00, 8'hC3);
      req_valid = 0;
      expand_en = 1;
      $display("t_port done");
   endtask : t_port

   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1;
      t_reset;
      t_tclk;
      t_rw;
      t_port;
      print_verdict;
   end

   initial
   begin
      repeat (2000) @(posedge clk);
      failures++;
      print_verdict;
   end
endmodule : elbi_bus_tb
